// ### logic/rtc_cal_defs.svh
// register offsets, field positions, reset values and flag positions of the calendar block
// assumes a word-addressed 16-bit register port
`ifndef RTC_CAL_DEFS_SVH
`define RTC_CAL_DEFS_SVH

// ********************
// register offsets
// ********************
`define RTC_ADDR_HOUR_MIN    3'h0
`define RTC_ADDR_MONTH_DAY   3'h1
`define RTC_ADDR_YEAR_WEEK   3'h2
`define RTC_ADDR_FLAGS       3'h3
`define RTC_ADDR_ENABLES     3'h4

// ********************
// reset values
// ********************
`define RTC_RST_MINUTE       7'h00
`define RTC_RST_HOUR         6'h12
`define RTC_RST_MONTH        5'h01
`define RTC_RST_DAY          6'h01
`define RTC_RST_WEEKDAY      3'h0
`define RTC_RST_YEAR         8'h00

// ********************
// field positions
// ********************
`define RTC_PM_BIT           14
`define RTC_FLAG_MASK        16'hf1ff

// ********************
// flag bit positions
// ********************
`define RTC_F_REGULATION     15
`define RTC_F_SW1HZ          14
`define RTC_F_SW10HZ         13
`define RTC_F_SW100HZ        12
`define RTC_F_ALARM          8
`define RTC_F_DAY            7
`define RTC_F_HOUR           6
`define RTC_F_MINUTE         5
`define RTC_F_SECOND         4
`define RTC_F_HALF           3
`define RTC_F_QUARTER        2
`define RTC_F_EIGHTH         1
`define RTC_F_THIRTYSECOND   0

// ********************
// counter limits (bcd)
// ********************
`define RTC_MINUTE_LAST      8'h59
`define RTC_HOUR12_LAST      8'h12
`define RTC_HOUR12_FIRST     8'h01
`define RTC_HOUR12_PM_FLIP   6'h11
`define RTC_HOUR24_LAST      8'h23
`define RTC_MONTH_LAST       8'h12
`define RTC_YEAR_LAST        8'h99
`define RTC_WEEKDAY_LAST     3'h6

`endif

// ### logic/rtc_cal_pkg.sv
// types of the calendar block
// assumes nothing of its surroundings
`default_nettype none
package rtc_cal_pkg;

  // ********************
  // block state
  // ********************
  typedef struct packed {
    logic [6:0]  minute;
    logic [5:0]  hour;
    logic        pm_indicator;
    logic [4:0]  month;
    logic [5:0]  day;
    logic [2:0]  weekday_counter;
    logic [7:0]  year;
    logic [15:0] flags;
    logic [15:0] enables;
    logic [15:0] rdata;
    logic        irq;
  } rtc_state_type;

endpackage
`default_nettype wire

// ### logic/month_length.sv
// last day of a month in bcd, leap years taken from the two-digit bcd year
// assumes legal bcd month and year values
`default_nettype none
module month_length (
  input  wire logic [4:0] month,
  input  wire logic [7:0] year,
  output var  logic [5:0] last_day
);

  logic leap;

  // ********************
  // leap year and month length
  // ********************
  always_comb begin
    if (year[4] == 1'b0) begin
      leap = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) || (year[3:0] == 4'h8);
    end else begin
      leap = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
    end
    unique case (month)
      5'h02:   last_day = leap ? 6'h29 : 6'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   last_day = 6'h30;
      default: last_day = 6'h31;
    endcase
  end

endmodule // month_length
`default_nettype wire

// ### logic/rtc_calendar.sv
// calendar counters and interrupt flag/enable registers of the real-time clock
// assumes the event inputs are one-cycle pulses from logic on clk, and a register
// port whose read data appears one cycle after the read strobe
//
// Decided for this implementation: the plain strobed port and the register addresses.
`default_nettype none
`include "rtc_cal_defs.svh"
module rtc_calendar
  import rtc_cal_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [15:0] rdata,
  output var  logic        irq,
  input  wire logic        twentyfour_hour_select,
  input  wire logic        minute_evt,
  input  wire logic        second_evt,
  input  wire logic        half_second_evt,
  input  wire logic        quarter_second_evt,
  input  wire logic        eighth_second_evt,
  input  wire logic        thirtysecond_second_evt,
  input  wire logic        alarm_evt,
  input  wire logic        stopwatch_1hz_evt,
  input  wire logic        stopwatch_10hz_evt,
  input  wire logic        stopwatch_100hz_evt,
  input  wire logic        regulation_done_evt
);

  rtc_state_type st;
  rtc_state_type next_st;
  logic [5:0]    last_day;
  logic          hour_roll;
  logic          day_roll;
  logic [15:0]   flag_set;
  logic [15:0]   flag_clr;

  // ********************
  // bcd helper
  // ********************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    if (v == last) begin
      return first;
    end else if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      return 8'(v + 8'h01);
    end
  endfunction

  month_length u_month_length (
    .month    (st.month),
    .year     (st.year),
    .last_day (last_day)
  );

  // ********************
  // next state
  // ********************
  always_comb begin
    next_st   = st;
    hour_roll = minute_evt && ({1'b0, st.minute} == `RTC_MINUTE_LAST);
    if (twentyfour_hour_select) begin
      day_roll = hour_roll && ({2'b00, st.hour} == `RTC_HOUR24_LAST);
    end else begin
      day_roll = hour_roll && (st.hour == `RTC_HOUR12_PM_FLIP) && st.pm_indicator;
    end

    // minute, hour and date counting
    if (minute_evt) begin
      next_st.minute = 7'(bcd_inc({1'b0, st.minute}, `RTC_MINUTE_LAST, 8'h00));
    end
    if (hour_roll) begin
      if (twentyfour_hour_select) begin
        next_st.hour         = 6'(bcd_inc({2'b00, st.hour}, `RTC_HOUR24_LAST, 8'h00));
        next_st.pm_indicator = 1'b0;
      end else begin
        next_st.hour = 6'(bcd_inc({2'b00, st.hour}, `RTC_HOUR12_LAST, `RTC_HOUR12_FIRST));
        if (st.hour == `RTC_HOUR12_PM_FLIP) begin
          next_st.pm_indicator = ~st.pm_indicator;
        end
      end
    end
    if (day_roll) begin
      next_st.day = 6'(bcd_inc({2'b00, st.day}, {2'b00, last_day}, 8'h01));
      if (st.weekday_counter == `RTC_WEEKDAY_LAST) begin
        next_st.weekday_counter = 3'h0;
      end else begin
        next_st.weekday_counter = 3'(st.weekday_counter + 3'h1);
      end
      if (st.day == last_day) begin
        next_st.month = 5'(bcd_inc({3'b000, st.month}, `RTC_MONTH_LAST, 8'h01));
        if (st.month == 5'(`RTC_MONTH_LAST)) begin
          next_st.year = bcd_inc(st.year, `RTC_YEAR_LAST, 8'h00);
        end
      end
    end

    // software writes to the counters win over a count in the same cycle
    if (wr) begin
      unique case (addr)
        `RTC_ADDR_HOUR_MIN: begin
          next_st.minute = wdata[6:0];
          next_st.hour   = wdata[13:8];
          if (!twentyfour_hour_select || !wdata[`RTC_PM_BIT]) begin
            next_st.pm_indicator = wdata[`RTC_PM_BIT];
          end
        end
        `RTC_ADDR_MONTH_DAY: begin
          next_st.month = wdata[12:8];
          next_st.day   = wdata[5:0];
        end
        `RTC_ADDR_YEAR_WEEK: begin
          next_st.weekday_counter = wdata[10:8];
          next_st.year            = wdata[7:0];
        end
        `RTC_ADDR_ENABLES: begin
          next_st.enables = wdata & `RTC_FLAG_MASK;
        end
        default: begin
        end
      endcase
    end

    // event flags: a set in the cycle of a clear wins
    flag_set                          = 16'h0000;
    flag_set[`RTC_F_REGULATION]       = regulation_done_evt;
    flag_set[`RTC_F_SW1HZ]            = stopwatch_1hz_evt;
    flag_set[`RTC_F_SW10HZ]           = stopwatch_10hz_evt;
    flag_set[`RTC_F_SW100HZ]          = stopwatch_100hz_evt;
    flag_set[`RTC_F_ALARM]            = alarm_evt;
    flag_set[`RTC_F_DAY]              = day_roll;
    flag_set[`RTC_F_HOUR]             = hour_roll;
    flag_set[`RTC_F_MINUTE]           = minute_evt;
    flag_set[`RTC_F_SECOND]           = second_evt;
    flag_set[`RTC_F_HALF]             = half_second_evt;
    flag_set[`RTC_F_QUARTER]          = quarter_second_evt;
    flag_set[`RTC_F_EIGHTH]           = eighth_second_evt;
    flag_set[`RTC_F_THIRTYSECOND]     = thirtysecond_second_evt;
    flag_clr = (wr && addr == `RTC_ADDR_FLAGS) ? wdata : 16'h0000;
    next_st.flags = ((st.flags & ~flag_clr) | flag_set) & `RTC_FLAG_MASK;

    next_st.irq = |(next_st.flags & next_st.enables);

    // read data stands for the one cycle after the strobe
    next_st.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `RTC_ADDR_HOUR_MIN: begin
          next_st.rdata = {1'b0, st.pm_indicator & ~twentyfour_hour_select, st.hour, 1'b0, st.minute};
        end
        `RTC_ADDR_MONTH_DAY: begin
          next_st.rdata = {3'b000, st.month, 2'b00, st.day};
        end
        `RTC_ADDR_YEAR_WEEK: begin
          next_st.rdata = {5'b00000, st.weekday_counter, st.year};
        end
        `RTC_ADDR_FLAGS: begin
          next_st.rdata = st.flags;
        end
        `RTC_ADDR_ENABLES: begin
          next_st.rdata = st.enables;
        end
        default: begin
        end
      endcase
    end
  end

  // ********************
  // state register
  // ********************
  always_ff @(posedge clk) begin
    if (srst) begin
      st.minute          <= `RTC_RST_MINUTE;
      st.hour            <= `RTC_RST_HOUR;
      st.pm_indicator    <= 1'b0;
      st.month           <= `RTC_RST_MONTH;
      st.day             <= `RTC_RST_DAY;
      st.weekday_counter <= `RTC_RST_WEEKDAY;
      st.year            <= `RTC_RST_YEAR;
      st.flags           <= 16'h0000;
      st.enables         <= 16'h0000;
      st.rdata           <= 16'h0000;
      st.irq             <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq   = st.irq;

  // ********************
  // checks
  // ********************
  irq_level_a: assert property (@(posedge clk) disable iff (srst)
    irq == |(st.flags & st.enables))
    else $error("interrupt output disagrees with flags and enables");

  alarm_set_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && alarm_evt) |=> st.flags[`RTC_F_ALARM])
    else $error("alarm flag not set by its event");

  flag_clear_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr && addr == `RTC_ADDR_FLAGS && wdata[`RTC_F_SECOND] && !second_evt)
    |=> !st.flags[`RTC_F_SECOND])
    else $error("second flag not cleared by writing one");

  flag_keep_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr && addr == `RTC_ADDR_FLAGS && !wdata[`RTC_F_ALARM] && st.flags[`RTC_F_ALARM])
    |=> st.flags[`RTC_F_ALARM])
    else $error("alarm flag lost on a write of zero");

  reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
    st.flags[11:9] == 3'b000 && st.enables[11:9] == 3'b000)
    else $error("reserved bits not zero");

  minute_wrap_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && minute_evt && st.minute == 7'h59 && !wr)
    |=> st.minute == 7'h00 && st.flags[`RTC_F_HOUR])
    else $error("minute counter did not wrap from 59");

  hour12_wrap_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && hour_roll && !twentyfour_hour_select && st.hour == 6'h12 && !wr)
    |=> st.hour == 6'h01)
    else $error("twelve-hour counter did not wrap to 1");

  hour24_wrap_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && hour_roll && twentyfour_hour_select && st.hour == 6'h23 && !wr)
    |=> st.hour == 6'h00 && !st.pm_indicator && st.flags[`RTC_F_DAY])
    else $error("twenty-four-hour wrap wrong");

  pm_read_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd && addr == `RTC_ADDR_HOUR_MIN && twentyfour_hour_select) |=> rdata[`RTC_PM_BIT] == 1'b0)
    else $error("pm bit read as one in twenty-four-hour mode");

  feb_end_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll && !wr && st.month == 5'h02 && st.day == 6'h28 && st.year[0])
    |=> st.day == 6'h01 && st.month == 5'h03)
    else $error("february did not end on day 28");

  weekday_range_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll && !wr && st.weekday_counter == 3'h6) |=> st.weekday_counter == 3'h0)
    else $error("weekday did not wrap after saturday");

  year_wrap_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll && !wr && st.month == 5'h12 && st.day == 6'h31 && st.year == 8'h99)
    |=> st.year == 8'h00 && st.month == 5'h01)
    else $error("year did not wrap from 99");

  read_once_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && !rd) |=> rdata == 16'h0000)
    else $error("read data present without a read");

  enable_rw_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr && addr == `RTC_ADDR_ENABLES) ##1 (clk_en && rd && addr == `RTC_ADDR_ENABLES && !wr)
    |=> rdata == ($past(wdata, 2) & `RTC_FLAG_MASK))
    else $error("enable register did not read back");

  hm_reserved_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd && addr == `RTC_ADDR_HOUR_MIN) |=> rdata[15] == 1'b0 && rdata[7] == 1'b0)
    else $error("reserved hour and minute bits read as one");

  md_reserved_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd && addr == `RTC_ADDR_MONTH_DAY) |=> rdata[15:13] == 3'b000 && rdata[7:6] == 2'b00)
    else $error("reserved month and day bits read as one");

  yw_reserved_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd && addr == `RTC_ADDR_YEAR_WEEK) |=> rdata[15:11] == 5'h00)
    else $error("reserved year and weekday bits read as one");

  unmapped_read_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd && addr > `RTC_ADDR_ENABLES) |=> rdata == 16'h0000)
    else $error("unmapped register read as nonzero");

  hour_carry_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && hour_roll && twentyfour_hour_select && st.hour == 6'h19 && !wr)
    |=> st.hour == 6'h20)
    else $error("hour ones digit did not carry into the tens");

  pm_toggle_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && hour_roll && !twentyfour_hour_select && st.hour == 6'h11 && !wr)
    |=> st.hour == 6'h12 && st.pm_indicator != $past(st.pm_indicator))
    else $error("pm bit did not flip going from 11 to 12");

  pm_write_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr && addr == `RTC_ADDR_HOUR_MIN && twentyfour_hour_select && wdata[`RTC_PM_BIT] && !hour_roll)
    |=> st.pm_indicator == $past(st.pm_indicator))
    else $error("pm bit took a write of one in twenty-four-hour mode");

  pm_clear_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && hour_roll && twentyfour_hour_select && !wr) |=> !st.pm_indicator)
    else $error("pm bit not cleared at the hour count");

  short_month_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll && !wr && st.day == 6'h30 &&
     (st.month == 5'h04 || st.month == 5'h06 || st.month == 5'h09 || st.month == 5'h11)) |=> st.day == 6'h01)
    else $error("short month did not end on day 30");

  leap_day_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll && !wr && st.month == 5'h02 && st.day == 6'h28 && !st.year[4] && st.year[3:0] == 4'h4)
    |=> st.day == 6'h29 && st.month == 5'h02)
    else $error("leap year february ended on day 28");

  weekday_step_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll && !wr && st.weekday_counter == 3'h0) |=> st.weekday_counter == 3'h1)
    else $error("weekday did not advance from sunday");

  day_flag_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && day_roll) |=> st.flags[`RTC_F_DAY])
    else $error("day flag not set on a new day");

  irq_rise_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && second_evt && st.enables[`RTC_F_SECOND] && !(wr && addr == `RTC_ADDR_ENABLES))
    |=> irq)
    else $error("enabled event did not raise the interrupt");

  irq_mask_a: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr && addr == `RTC_ADDR_ENABLES && wdata == 16'h0000) |=> !irq)
    else $error("interrupt stayed high with all enables off");

  freeze_a: assert property (@(posedge clk) disable iff (srst)
    !clk_en |=> $stable(st))
    else $error("state changed while clock enable low");

endmodule // rtc_calendar
`default_nettype wire

// ### verif/rtc_calendar_bench.sv
// self-checking bench of the calendar counters and the event flag/enable registers
// assumes rtc_calendar with its word-addressed register port and one-cycle event pulses
`default_nettype none
`include "rtc_cal_defs.svh"
module rtc_calendar_bench
  import rtc_cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************
  // signals
  // ********************
  logic        clk;
  logic        srst;
  logic        clk_en;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        irq;
  logic        twentyfour_hour_select;
  logic [10:0] ev;
  int          fails;
  int          num_checks;
  int          cycles;
  int          flag_pos [11];

  rtc_calendar u_rtc_calendar (
    .clk                     (clk),
    .srst                    (srst),
    .clk_en                  (clk_en),
    .addr                    (addr),
    .wdata                   (wdata),
    .wr                      (wr),
    .rd                      (rd),
    .rdata                   (rdata),
    .irq                     (irq),
    .twentyfour_hour_select  (twentyfour_hour_select),
    .minute_evt              (ev[5]),
    .second_evt              (ev[4]),
    .half_second_evt         (ev[3]),
    .quarter_second_evt      (ev[2]),
    .eighth_second_evt       (ev[1]),
    .thirtysecond_second_evt (ev[0]),
    .alarm_evt               (ev[6]),
    .stopwatch_1hz_evt       (ev[9]),
    .stopwatch_10hz_evt      (ev[8]),
    .stopwatch_100hz_evt     (ev[7]),
    .regulation_done_evt     (ev[10])
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ********************
  // tasks
  // ********************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks made %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stands one cycle only, then falls back to zero
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
    #1;
    check(rdata, 16'h0000);
  endtask

  task automatic pulse(input logic [10:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 11'h000;
  endtask

  task automatic set_mode(input logic m);
    @(posedge clk);
    twentyfour_hour_select <= m;
  endtask

  // load the calendar, count one minute, compare all three counter registers
  task automatic cal(input logic m, input logic [15:0] hm, md, yw, ehm, emd, eyw);
    set_mode(m);
    wr_reg(`RTC_ADDR_HOUR_MIN, hm);
    wr_reg(`RTC_ADDR_MONTH_DAY, md);
    wr_reg(`RTC_ADDR_YEAR_WEEK, yw);
    pulse(11'h020);
    rd_chk(`RTC_ADDR_HOUR_MIN, ehm);
    rd_chk(`RTC_ADDR_MONTH_DAY, emd);
    rd_chk(`RTC_ADDR_YEAR_WEEK, eyw);
  endtask

  task automatic chk_reset;
    rd_chk(`RTC_ADDR_HOUR_MIN, 16'h1200);
    rd_chk(`RTC_ADDR_MONTH_DAY, 16'h0101);
    rd_chk(`RTC_ADDR_YEAR_WEEK, 16'h0000);
    rd_chk(`RTC_ADDR_FLAGS, 16'h0000);
    rd_chk(`RTC_ADDR_ENABLES, 16'h0000);
    rd_chk(3'h5, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
  endtask

  // ********************
  // hang guard
  // ********************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      give_verdict();
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    twentyfour_hour_select = 1'b1;
    ev = 11'h000;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    flag_pos = '{15, 14, 13, 12, 8, 5, 4, 3, 2, 1, 0};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    chk_reset();
    wr_reg(`RTC_ADDR_ENABLES, 16'hffff);
    rd_chk(`RTC_ADDR_ENABLES, 16'hf1ff);
    wr_reg(3'h5, 16'h0000);
    rd_chk(`RTC_ADDR_ENABLES, 16'hf1ff);
    // write then read back with no gap between the strobes
    @(posedge clk);
    addr  <= `RTC_ADDR_ENABLES;
    wdata <= 16'h1e5a;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    check(rdata, 16'h105a);
    wr_reg(`RTC_ADDR_ENABLES, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << (10 - i));
      #1;
      check({15'h0000, irq}, 16'h0000);
      rd_chk(`RTC_ADDR_FLAGS, 16'h0001 << flag_pos[i]);
      wr_reg(`RTC_ADDR_FLAGS, ~(16'h0001 << flag_pos[i]));
      rd_chk(`RTC_ADDR_FLAGS, 16'h0001 << flag_pos[i]);
      wr_reg(`RTC_ADDR_FLAGS, 16'h0001 << flag_pos[i]);
      rd_chk(`RTC_ADDR_FLAGS, 16'h0000);
    end
    // interrupt follows flag and enable, masked and cleared
    wr_reg(`RTC_ADDR_ENABLES, 16'h0010);
    pulse(11'h010);
    #1;
    check({15'h0000, irq}, 16'h0001);
    wr_reg(`RTC_ADDR_ENABLES, 16'h0000);
    #1;
    check({15'h0000, irq}, 16'h0000);
    wr_reg(`RTC_ADDR_ENABLES, 16'h0010);
    #1;
    check({15'h0000, irq}, 16'h0001);
    wr_reg(`RTC_ADDR_FLAGS, 16'h0010);
    #1;
    check({15'h0000, irq}, 16'h0000);
    // an event in the same cycle as its clear keeps the flag
    @(posedge clk);
    addr  <= `RTC_ADDR_FLAGS;
    wdata <= 16'h0001;
    wr    <= 1'b1;
    ev    <= 11'h001;
    @(posedge clk);
    wr    <= 1'b0;
    ev    <= 11'h000;
    rd_chk(`RTC_ADDR_FLAGS, 16'h0001);
    wr_reg(`RTC_ADDR_FLAGS, 16'hffff);
    // frozen clock enable drops events
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(11'h010);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(`RTC_ADDR_FLAGS, 16'h0000);
    // calendar counting; all writes happen while nothing counts
    cal(1'b1, 16'h2359, 16'h0228, 16'h0023, 16'h0000, 16'h0301, 16'h0123);
    rd_chk(`RTC_ADDR_FLAGS, 16'h00e0);
    wr_reg(`RTC_ADDR_FLAGS, 16'hffff);
    cal(1'b1, 16'h2359, 16'h0228, 16'h0024, 16'h0000, 16'h0229, 16'h0124);
    cal(1'b1, 16'h2359, 16'h0229, 16'h0024, 16'h0000, 16'h0301, 16'h0124);
    cal(1'b1, 16'h2359, 16'he4f0, 16'hfe00, 16'h0000, 16'h0501, 16'h0000);
    cal(1'b1, 16'h2359, 16'h1231, 16'h0699, 16'h0000, 16'h0101, 16'h0000);
    cal(1'b1, 16'h1959, 16'h0115, 16'h0345, 16'h2000, 16'h0115, 16'h0345);
    cal(1'b1, 16'h0948, 16'h0930, 16'h0209, 16'h0949, 16'h0930, 16'h0209);
    cal(1'b0, 16'h1159, 16'h0101, 16'h0000, 16'h5200, 16'h0101, 16'h0000);
    cal(1'b0, 16'h5259, 16'h0101, 16'h0000, 16'h4100, 16'h0101, 16'h0000);
    cal(1'b0, 16'h5159, 16'h1130, 16'h0198, 16'h1200, 16'h1201, 16'h0298);
    cal(1'b0, 16'h1259, 16'h0101, 16'h0000, 16'h0100, 16'h0101, 16'h0000);
    // pm bit in twenty-four-hour mode
    set_mode(1'b1);
    wr_reg(`RTC_ADDR_HOUR_MIN, 16'hc590);
    rd_chk(`RTC_ADDR_HOUR_MIN, 16'h0510);
    set_mode(1'b0);
    rd_chk(`RTC_ADDR_HOUR_MIN, 16'h0510);
    wr_reg(`RTC_ADDR_HOUR_MIN, 16'h4559);
    rd_chk(`RTC_ADDR_HOUR_MIN, 16'h4559);
    set_mode(1'b1);
    rd_chk(`RTC_ADDR_HOUR_MIN, 16'h0559);
    pulse(11'h020);
    set_mode(1'b0);
    rd_chk(`RTC_ADDR_HOUR_MIN, 16'h0600);
    // second reset in mid-run
    wr_reg(`RTC_ADDR_ENABLES, 16'h00e0);
    #1;
    check({15'h0000, irq}, 16'h0001);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_reset();
    give_verdict();
  end
endmodule // rtc_calendar_bench
`default_nettype wire
